// >>> mfe_addr_former.sv
// Forms the 15-bit memory address of each reference from the fields.
// Assumes the sequencer presents one reference per request pulse.
`timescale 1ns/100ps
module mfe_addr_former
  import mfe_pkg::*;
(
  input  wire logic             clock,         // Core clock
  input  wire logic             sys_rst,       // Async reset, active high
  input  wire logic             ref_start,     // Reference request pulse
  input  mfe_ref_kind_type      ref_kind,      // Kind of reference
  input  wire logic             ref_cur_page,  // Page bit of the word
  input  wire logic [6:0]       ref_offset,    // Word bits 5-11
  input  wire logic [11:0]      ref_pc,        // Program counter
  input  wire logic [11:0]      ref_pointer,   // Pointer word as read
  input  wire logic [2:0]       instr_field,   // Active instruction field
  input  wire logic [2:0]       operand_field, // Operand field
  output logic [PHYS_W-1:0]     mem_addr_reg,  // Formed address
  output logic                  mem_valid_reg, // Address strobe
  output logic                  autoidx_reg,   // Pointer needs pre-increment
  output logic [11:0]           ptr_wb_reg     // Incremented pointer
);

  logic [PHYS_W-1:0] addr_next;
  logic              autoidx_next;
  logic [11:0]       ptr_wb_next;
  logic [11:0]       loc;

  // ----------------------------------------------------------------
  // Field selection per reference kind
  // ----------------------------------------------------------------
  always_comb begin
    loc          = page_addr(ref_cur_page, ref_pc, ref_offset);
    addr_next    = mem_addr_reg;
    autoidx_next = autoidx_reg;
    ptr_wb_next  = ptr_wb_reg;
    if (ref_start) begin
      case (ref_kind)
        REF_FETCH: begin
          addr_next = {instr_field, ref_pc};
        end
        REF_POINTER: begin
          // Autoindex in whatever field is the instruction field
          addr_next    = {instr_field, loc};
          autoidx_next = (loc[11:3] == AUTOIDX_BLOCK);
        end
        REF_DIRECT: begin
          addr_next = {instr_field, loc};
        end
        REF_INDIRECT: begin
          // Operand lives in the operand field at the (bumped) pointer
          ptr_wb_next = inc_word(ref_pointer);
          addr_next   = {operand_field, (autoidx_reg ? inc_word(ref_pointer) : ref_pointer)};
        end
        REF_INT_STORE: begin
          addr_next = {INT_FIELD, INT_STORE_ADDR};
        end
        REF_INT_FETCH: begin
          addr_next = {INT_FIELD, INT_FETCH_ADDR};
        end
        default: begin
          addr_next = mem_addr_reg;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mem_addr_reg  <= '0;
      mem_valid_reg <= 1'b0;
      autoidx_reg   <= 1'b0;
      ptr_wb_reg    <= '0;
    end else begin
      mem_addr_reg  <= addr_next;
      mem_valid_reg <= ref_start;
      autoidx_reg   <= autoidx_next;
      ptr_wb_reg    <= ptr_wb_next;
    end
  end

endmodule : mfe_addr_former

// >>> mfe_field_ctrl.sv
// Top of the memory field extension: field registers, field
// instructions, jump commit, interrupt save and address forming.
// Assumes the sequencer, interrupt logic and memory share the core
// clock; only the console switches come from outside that domain.
`timescale 1ns/100ps

module mfe_field_ctrl
  import mfe_pkg::*;
(
  input  wire logic             clock,           // Core clock, 100 MHz
  input  wire logic             sys_rst,         // Async reset, active high
  input  wire logic             iot_start,       // Field instruction pulse
  input  wire logic [11:0]      iot_word,        // Instruction word
  input  wire logic [11:0]      ac_in,           // Accumulator value
  output logic [11:0]           ac_out_reg,      // Accumulator result
  output logic                  ac_we_reg,       // Result replaces accumulator
  output logic                  iot_busy_reg,    // Instruction in progress
  output logic                  iot_done,        // End-of-instruction pulse
  input  wire logic             jump_exec,       // Jump or call executes
  input  wire logic             int_request,     // Interrupt request pulse
  input  wire logic             int_enabled,     // Interrupts enabled
  output logic                  int_taken_reg,   // Interrupt accepted pulse
  input  wire logic             console_load,    // Console load switch
  input  wire logic [2:0]       console_field,   // Console field switches
  output logic [2:0]            instr_field_reg, // Active instruction field
  output logic [2:0]            instr_field_buffer, // Pending field
  output logic [2:0]            operand_field_reg,  // Operand field
  output logic [5:0]            saved_field_pair,   // Saved fields
  input  wire logic             ref_start,       // Reference request pulse
  input  mfe_ref_kind_type      ref_kind,        // Kind of reference
  input  wire logic             ref_cur_page,    // Page bit
  input  wire logic [6:0]       ref_offset,      // Word bits 5-11
  input  wire logic [11:0]      ref_pc,          // Program counter
  input  wire logic [11:0]      ref_pointer,     // Pointer word as read
  output logic [PHYS_W-1:0]     mem_addr_reg,    // Formed address
  output logic                  mem_valid_reg,   // Address strobe
  output logic                  autoidx_reg,     // Pointer pre-increment
  output logic [11:0]           ptr_wb_reg       // Incremented pointer
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  mfe_iot_state_type state_reg;
  mfe_iot_state_type state_next;
  logic [11:0]       ac_out_next;
  logic              ac_we_next;
  logic [2:0]        if_next;
  logic [2:0]        ib_next;
  logic [2:0]        df_next;
  logic [5:0]        sf_next;
  logic              int_take;
  logic              iot_take;
  logic [2:0]        field_num;
  logic [2:0]        cons_load_sync;   // Two sync stages plus edge history
  logic [2:0]        cons_field_s1;
  logic [2:0]        cons_field_s2;
  logic              cons_pulse;

  // ----------------------------------------------------------------
  // Console switch synchronisers
  // ----------------------------------------------------------------
  // Only the second stage and later are looked at by logic
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cons_load_sync <= 3'h0;
      cons_field_s1  <= FIELD_RST;
      cons_field_s2  <= FIELD_RST;
    end else begin
      cons_load_sync <= {cons_load_sync[1:0], console_load};
      cons_field_s1  <= console_field;
      cons_field_s2  <= cons_field_s1;
    end
  end

  // Rising edge of the synchronised load switch
  assign cons_pulse = cons_load_sync[1] & ~cons_load_sync[2];

  // ----------------------------------------------------------------
  // Field instruction sequencing
  // ----------------------------------------------------------------
  // Requests while busy are dropped; the sequencer waits for done
  assign iot_take  = iot_start && (state_reg == IOT_IDLE);
  assign int_take  = int_request && int_enabled;
  assign field_num = iot_word[FIELD_NUM_LSB +: FIELD_W];

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      IOT_IDLE: begin
        if (iot_take) begin
          state_next = IOT_RUN;
        end
      end
      IOT_RUN: begin
        if (iot_done) begin
          state_next = IOT_IDLE;
        end
      end
      default: begin
        state_next = IOT_IDLE;
      end
    endcase
  end

  // Accumulator result, computed at start and held to the next start
  always_comb begin
    ac_out_next = ac_out_reg;
    ac_we_next  = ac_we_reg;
    if (iot_take) begin
      ac_out_next = ac_in;
      ac_we_next  = 1'b0;
      if (iot_word == READ_OPERAND_FIELD_OP) begin
        ac_out_next[AC_HI_LSB +: FIELD_W] = ac_in[AC_HI_LSB +: FIELD_W] | operand_field_reg;
        ac_we_next = 1'b1;
      end else if (iot_word == READ_INSTR_FIELD_OP) begin
        ac_out_next[AC_HI_LSB +: FIELD_W] = ac_in[AC_HI_LSB +: FIELD_W] | instr_field_reg;
        ac_we_next = 1'b1;
      end else if (iot_word == READ_SAVED_FIELDS_OP) begin
        ac_out_next[AC_HI_LSB +: FIELD_W] = ac_in[AC_HI_LSB +: FIELD_W]
                                            | saved_field_pair[SAVED_IF_LSB +: FIELD_W];
        ac_out_next[AC_LO_LSB +: FIELD_W] = ac_in[AC_LO_LSB +: FIELD_W]
                                            | saved_field_pair[SAVED_DF_LSB +: FIELD_W];
        ac_we_next = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Field registers
  // ----------------------------------------------------------------
  // Interrupt wins over a jump or instruction in the same cycle, since
  // it must save the fields as they stood and force field 0.
  always_comb begin
    if_next = instr_field_reg;
    ib_next = instr_field_buffer;
    df_next = operand_field_reg;
    sf_next = saved_field_pair;
    if (int_take) begin
      sf_next[SAVED_IF_LSB +: FIELD_W] = instr_field_reg;
      sf_next[SAVED_DF_LSB +: FIELD_W] = operand_field_reg;
      ib_next = INT_FIELD;
      if_next = INT_FIELD;
      df_next = INT_FIELD;
    end else if (cons_pulse) begin
      if_next = cons_field_s2;
      ib_next = cons_field_s2;
    end else begin
      if (jump_exec) begin
        if_next = instr_field_buffer;
      end
      if (iot_take) begin
        if ((iot_word & FIELD_CHG_MASK) == FIELD_CHG_MATCH) begin
          if (iot_word[CHG_OPERAND_BIT]) begin
            df_next = field_num;
          end
          if (iot_word[CHG_INSTR_BIT]) begin
            ib_next = field_num;
          end
        end else if (iot_word == RESTORE_FIELDS_OP) begin
          ib_next = saved_field_pair[SAVED_IF_LSB +: FIELD_W];
          df_next = saved_field_pair[SAVED_DF_LSB +: FIELD_W];
        end
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg          <= IOT_IDLE;
      iot_busy_reg       <= 1'b0;
      ac_out_reg         <= 12'h000;
      ac_we_reg          <= 1'b0;
      instr_field_reg    <= FIELD_RST;
      instr_field_buffer <= FIELD_RST;
      operand_field_reg  <= FIELD_RST;
      saved_field_pair   <= SAVED_RST;
      int_taken_reg      <= 1'b0;
    end else begin
      state_reg          <= state_next;
      iot_busy_reg       <= (state_next == IOT_RUN);
      ac_out_reg         <= ac_out_next;
      ac_we_reg          <= ac_we_next;
      instr_field_reg    <= if_next;
      instr_field_buffer <= ib_next;
      operand_field_reg  <= df_next;
      saved_field_pair   <= sf_next;
      int_taken_reg      <= int_take;
    end
  end

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  mfe_iot_timer #(
    .CYCLES (IOT_CYCLES),
    .CNT_W  (10)
  ) u_timer (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .start      (iot_take),
    .expire_reg (iot_done)
  );

  mfe_addr_former u_former (
    .clock         (clock),
    .sys_rst       (sys_rst),
    .ref_start     (ref_start),
    .ref_kind      (ref_kind),
    .ref_cur_page  (ref_cur_page),
    .ref_offset    (ref_offset),
    .ref_pc        (ref_pc),
    .ref_pointer   (ref_pointer),
    .instr_field   (instr_field_reg),
    .operand_field (operand_field_reg),
    .mem_addr_reg  (mem_addr_reg),
    .mem_valid_reg (mem_valid_reg),
    .autoidx_reg   (autoidx_reg),
    .ptr_wb_reg    (ptr_wb_reg)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // Edges since an accepted start; the span is too long for a plain delay
  localparam logic [9:0] DONE_CNT = 10'(IOT_CYCLES + 1);
  logic [9:0]            span_cnt_reg;
  logic [9:0]            span_cnt_next;

  always_comb begin
    span_cnt_next = span_cnt_reg;
    if (iot_take) begin
      span_cnt_next = 10'h001;
    end else if (span_cnt_reg == DONE_CNT) begin
      span_cnt_next = 10'h000;
    end else if (span_cnt_reg != 10'h000) begin
      span_cnt_next = span_cnt_reg + 10'h001;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      span_cnt_reg <= 10'h000;
    end else begin
      span_cnt_reg <= span_cnt_next;
    end
  end

  a_iot_done_time: assert property (iot_done == (span_cnt_reg == DONE_CNT))
    else $error("field instruction did not end on time");
  a_iot_no_early: assert property (iot_take |=> !iot_done [*8])
    else $error("field instruction ended early");
  a_df_change: assert property (iot_take && !int_take && !cons_pulse
      && ((iot_word & FIELD_CHG_MASK) == FIELD_CHG_MATCH) && iot_word[0]
      |=> operand_field_reg == $past(iot_word[5:3]))
    else $error("operand field not loaded");
  a_if_held_cif: assert property (iot_take && !jump_exec && !int_take && !cons_pulse
      |=> instr_field_reg == $past(instr_field_reg))
    else $error("instruction field moved without jump");
  a_jump_commit: assert property (jump_exec && !int_take && !cons_pulse
      |=> instr_field_reg == $past(instr_field_buffer))
    else $error("jump did not commit buffer");
  a_rdf_or: assert property (iot_take && iot_word == READ_OPERAND_FIELD_OP
      |=> ac_we_reg && ac_out_reg == ($past(ac_in) | {6'h00, $past(operand_field_reg), 3'h0}))
    else $error("read operand field result wrong");
  a_rif_or: assert property (iot_take && iot_word == READ_INSTR_FIELD_OP
      |=> ac_we_reg && ac_out_reg == ($past(ac_in) | {6'h00, $past(instr_field_reg), 3'h0}))
    else $error("read instruction field result wrong");
  a_rib_or: assert property (iot_take && iot_word == READ_SAVED_FIELDS_OP
      |=> ac_out_reg == ($past(ac_in) | {6'h00, $past(saved_field_pair)}))
    else $error("read saved fields result wrong");
  a_rmf_restore: assert property (iot_take && iot_word == RESTORE_FIELDS_OP && !int_take && !cons_pulse
      |=> instr_field_buffer == $past(saved_field_pair[5:3])
          && operand_field_reg == $past(saved_field_pair[2:0]))
    else $error("restore fields wrong");
  a_int_save: assert property (int_take
      |=> saved_field_pair == {$past(instr_field_reg), $past(operand_field_reg)}
          && instr_field_reg == INT_FIELD && int_taken_reg)
    else $error("interrupt save wrong");
  a_fetch_field: assert property (ref_start && ref_kind == REF_FETCH
      |=> mem_valid_reg && mem_addr_reg == {$past(instr_field_reg), $past(ref_pc)})
    else $error("fetch not from instruction field");
  a_int_vector: assert property (ref_start && ref_kind == REF_INT_FETCH
      |=> mem_addr_reg == 15'h0001)
    else $error("interrupt entry not field 0 location 1");

  c_jump_commit: cover property (iot_take && iot_word[CHG_INSTR_BIT] ##[1:500] jump_exec);
  c_int_restore: cover property (int_take ##[1:900] (iot_take && iot_word == RESTORE_FIELDS_OP));
  c_autoindex: cover property (ref_start && ref_kind == REF_POINTER ##1 autoidx_reg);

endmodule : mfe_field_ctrl

// >>> mfe_iot_timer.sv
// Fixed-length timer for one field instruction.
// Assumes start only arrives while the timer is idle.
`timescale 1ns/100ps
module mfe_iot_timer
  import mfe_pkg::*;
#(
  parameter int CYCLES = IOT_CYCLES,
  parameter int CNT_W  = 10
) (
  input  wire logic clock,       // Core clock
  input  wire logic sys_rst,     // Async reset, active high
  input  wire logic start,       // One-cycle start pulse
  output logic      expire_reg   // Pulse CYCLES edges after start
);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             expire_next;

  // ----------------------------------------------------------------
  // Count down; the last step raises the pulse
  // ----------------------------------------------------------------
  always_comb begin
    cnt_next    = cnt_reg;
    expire_next = 1'b0;
    if (start) begin
      cnt_next = CNT_W'(CYCLES);
    end else if (cnt_reg != '0) begin
      cnt_next    = cnt_reg - 1'b1;
      expire_next = (cnt_reg == CNT_W'(1));
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg    <= '0;
      expire_reg <= 1'b0;
    end else begin
      cnt_reg    <= cnt_next;
      expire_reg <= expire_next;
    end
  end

endmodule : mfe_iot_timer

// >>> mfe_mem_model.sv
// Stand-in core memory behind the address former: serves pointer words.
// Assumes one formed address per mem_valid pulse, all on the core clock.
`timescale 1ns/100ps
module mfe_mem_model
  import mfe_pkg::*;
(
  input  wire logic              clock,     // Core clock
  input  wire logic              sys_rst,   // Async reset, active high
  input  wire logic [PHYS_W-1:0] mem_addr,  // Formed address
  input  wire logic              mem_valid, // Address strobe
  output logic [11:0]            rdata_reg  // Word read, held like a buffer
);
  logic [11:0] rdata_next;
  // Content is a fixed scramble of the address, so the bench can predict it
  always_comb begin
    rdata_next = mem_valid ? (mem_addr[11:0] ^ 12'h05a5) : rdata_reg;
  end
  // Holds until the next read, as the sequencer samples it later
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) rdata_reg <= 12'h0000;
    else rdata_reg <= rdata_next;
  end
endmodule : mfe_mem_model

// >>> mfe_pkg.sv
// Constants, types and shared helpers of the memory field extension.
// Assumes a 12-bit word, 4096-word fields and a 100 MHz core clock.
package mfe_pkg;

  // ----------------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------------
  localparam int  FIELD_W       = 3;      // Field number width
  localparam int  WORD_W        = 12;     // Machine word width
  localparam int  PHYS_W        = 15;     // Field plus in-field address
  localparam int  OFFSET_W      = 7;      // In-page word offset width
  localparam int  CLK_PERIOD_NS = 10;     // Core clock period
  localparam real IOT_TIME_US   = 4.3;    // Field instruction time
  // Longest time, so the division rounds down
  localparam int  IOT_CYCLES    = int'(IOT_TIME_US * 1000.0) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  localparam logic [11:0] FIELD_CHG_MASK        = 12'hfc4;  // 62Nx with x < 4
  localparam logic [11:0] FIELD_CHG_MATCH       = 12'hc80;
  localparam int          CHG_OPERAND_BIT       = 0;        // Change operand field
  localparam int          CHG_INSTR_BIT         = 1;        // Change instruction field
  localparam logic [11:0] READ_OPERAND_FIELD_OP = 12'hc8c;  // Octal 6214
  localparam logic [11:0] READ_INSTR_FIELD_OP   = 12'hc94;  // Octal 6224
  localparam logic [11:0] READ_SAVED_FIELDS_OP  = 12'hc9c;  // Octal 6234
  localparam logic [11:0] RESTORE_FIELDS_OP     = 12'hca4;  // Octal 6244
  localparam int          FIELD_NUM_LSB         = 3;        // Word bits 6-8

  // ----------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------
  localparam int          AC_HI_LSB      = 3;       // Accumulator bits 6-8
  localparam int          AC_LO_LSB      = 0;       // Accumulator bits 9-11
  localparam int          SAVED_IF_LSB   = 3;       // Saved bits 0-2
  localparam int          SAVED_DF_LSB   = 0;       // Saved bits 3-5
  localparam logic [2:0]  FIELD_RST      = 3'h0;
  localparam logic [5:0]  SAVED_RST      = 6'h00;
  localparam logic [2:0]  INT_FIELD      = 3'h0;    // Field forced on interrupt
  localparam logic [11:0] INT_STORE_ADDR = 12'h000; // Return address slot
  localparam logic [11:0] INT_FETCH_ADDR = 12'h001; // Service entry
  localparam logic [8:0]  AUTOIDX_BLOCK  = 9'h001;  // Locations 10-17 octal

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    REF_FETCH     = 3'h0,
    REF_POINTER   = 3'h1,
    REF_DIRECT    = 3'h2,
    REF_INDIRECT  = 3'h3,
    REF_INT_STORE = 3'h4,
    REF_INT_FETCH = 3'h5
  } mfe_ref_kind_type;

  typedef enum logic {
    IOT_IDLE = 1'b0,
    IOT_RUN  = 1'b1
  } mfe_iot_state_type;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [11:0] page_addr(input logic       cur_page,
                                            input logic [11:0] pc,
                                            input logic [6:0]  offset);
    page_addr = {(cur_page ? pc[11:7] : 5'h00), offset};
  endfunction : page_addr

  function automatic logic [11:0] inc_word(input logic [11:0] w);
    inc_word = w + 12'h001;
  endfunction : inc_word

endpackage : mfe_pkg

// >>> test_memory_field_extension.sv
// Self-checking bench of the field extension, with a small field model.
// Assumes mfe_mem_model answers pointer reads; console switches are driven here.
`timescale 1ns/100ps
module test_memory_field_extension;
  import mfe_pkg::*;
  logic clock = 0, sys_rst = 1, iot_start = 0, jump_exec = 0, int_request = 0, int_enabled = 0;
  logic console_load = 0, ref_start = 0, ref_cur_page = 0, ac_we_reg, iot_busy_reg, iot_done;
  logic int_taken_reg, mem_valid_reg, autoidx_reg, aut;
  logic [11:0] iot_word = 0, ac_in = 0, ref_pc = 0, ac_out_reg, ptr_wb_reg, rdata, ptr;
  logic [2:0] console_field = 0, instr_field_reg, instr_field_buffer, operand_field_reg;
  logic [5:0] saved_field_pair;
  logic [6:0] ref_offset = 0;
  logic [PHYS_W-1:0] mem_addr_reg;
  mfe_ref_kind_type ref_kind = REF_FETCH;
  logic [11:0] ops [9] = '{12'h0c80, 12'h0c81, 12'h0c82, 12'h0c83, 12'h0c8c, 12'h0c94, 12'h0c9c, 12'h0ca4, 12'h0c85};
  integer seed = 32'hd7d8fd03, miscompares = 0, n_checks = 0, k, i, r;
  int if_m = 0, ib_m = 0, df_m = 0, sf_m = 0;
  mfe_field_ctrl mfe_field_ctrl_inst (.clock, .sys_rst, .iot_start, .iot_word, .ac_in, .ac_out_reg, .ac_we_reg,
    .iot_busy_reg, .iot_done, .jump_exec, .int_request, .int_enabled, .int_taken_reg, .console_load,
    .console_field, .instr_field_reg, .instr_field_buffer, .operand_field_reg, .saved_field_pair, .ref_start,
    .ref_kind, .ref_cur_page, .ref_offset, .ref_pc, .ref_pointer(rdata), .mem_addr_reg, .mem_valid_reg,
    .autoidx_reg, .ptr_wb_reg);
  mfe_mem_model mfe_mem_model_inst (.clock, .sys_rst, .mem_addr(mem_addr_reg), .mem_valid(mem_valid_reg),
    .rdata_reg(rdata));
  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [14:0] got, input logic [14:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task automatic fields;
    chk("instr_field", instr_field_reg, if_m);
    chk("instr_buffer", instr_field_buffer, ib_m);
    chk("operand_field", operand_field_reg, df_m);
  endtask : fields
  // ------------------------------------------------------------
  // Bus cycles, each predicted from the field model
  // ------------------------------------------------------------
  task automatic iot(input logic [11:0] w);
    logic [11:0] e;
    @(negedge clock);
    r = $random(seed);
    iot_start = 1;
    iot_word = w;
    ac_in = r[11:0];
    @(negedge clock);
    iot_start = 0;
    k = 0;
    do begin
      @(posedge clock);
      #1;
      k++;
      if (k == 1) chk("iot_busy", iot_busy_reg, 1);
    end while (iot_done !== 1'b1 && k < 1000);
    chk("iot_time", k, 430);
    if (k >= 1000) end_of_test();
    e = ac_in;
    if (w[11:6] == 6'h32 && !w[2] && w[0]) df_m = w[5:3];
    if (w[11:6] == 6'h32 && !w[2] && w[1]) ib_m = w[5:3];
    if (w == 12'h0c8c) e = ac_in | (df_m << 3);
    if (w == 12'h0c94) e = ac_in | (if_m << 3);
    if (w == 12'h0c9c) e = ac_in | sf_m;
    if (w == 12'h0ca4) {ib_m, df_m} = {sf_m >> 3, sf_m & 7};
    chk("ac_we", ac_we_reg, w inside {12'h0c8c, 12'h0c94, 12'h0c9c});
    chk("ac_out", ac_out_reg, e);
    fields();
  endtask : iot
  task automatic mref(input int kd);
    logic [11:0] loc;
    logic [14:0] e;
    @(negedge clock);
    {ref_pc, ref_offset, ref_cur_page} = 20'($random(seed));
    if (kd == 1 && i[0]) {ref_offset, ref_cur_page} = {4'h1, i[2:0], 1'b0};
    loc = {(ref_cur_page ? ref_pc[11:7] : 5'h00), ref_offset};
    ref_start = 1;
    ref_kind = mfe_ref_kind_type'(kd);
    e = kd == 0 ? {if_m[2:0], ref_pc} : kd < 3 ? {if_m[2:0], loc} : kd == 3 ? {df_m[2:0], 12'(ptr + aut)} : kd - 4;
    @(negedge clock);
    ref_start = 0;
    chk("mem_valid", mem_valid_reg, 1);
    chk("mem_addr", mem_addr_reg, e);
    if (kd == 1) {aut, ptr} = {loc[11:3] == 9'h001, loc ^ 12'h05a5};
    if (kd == 1) chk("autoidx", autoidx_reg, aut);
    if (kd == 3 && aut) chk("ptr_wb", ptr_wb_reg, 12'(ptr + 1));
  endtask : mref
  // ------------------------------------------------------------
  // Clock and main sequence
  // ------------------------------------------------------------
  initial begin
    forever #5 clock = ~clock;
  end
  // Random field numbers through every opcode, with jumps, interrupts, refs
  initial begin
    repeat (16) @(negedge clock);
    sys_rst = 0;
    fields();
    chk("saved_reset", saved_field_pair, 0);
    for (i = 0; i < 36; i++) begin
      r = $random(seed);
      iot(ops[i % 9] | ((i % 9 < 4 || i % 9 == 8) ? r[2:0] << 3 : 12'h0000));
      if (r[3]) begin
        @(negedge clock);
        jump_exec = 1;
        @(negedge clock);
        jump_exec = 0;
        if_m = ib_m;
        fields();
      end
      // Console load: synchronised rising edge sets field and buffer
      if (i % 9 == 2) begin
        @(negedge clock);
        console_field = r[8:6];
        console_load = 1;
        repeat (4) @(negedge clock);
        console_load = 0;
        if_m = r[8:6];
        ib_m = r[8:6];
        fields();
      end
      if (i % 9 == 5) begin
        @(negedge clock);
        int_request = 1;
        int_enabled = r[4];
        @(negedge clock);
        int_request = 0;
        chk("int_taken", int_taken_reg, r[4]);
        if (r[4]) begin
          sf_m = if_m * 8 + df_m;
          if_m = 0;
          ib_m = 0;
          df_m = 0;
        end
        chk("saved", saved_field_pair, sf_m);
        fields();
        if (r[4]) mref(4);
        if (r[4]) mref(5);
      end
      mref(r[5] ? 0 : 2);
      mref(1);
      mref(3);
    end
    end_of_test();
  end
endmodule : test_memory_field_extension
